// ===== shared/udma_defines.svh
// timing counts and constants shared by both burst ends
`ifndef UDMA_DEFINES_SVH
`define UDMA_DEFINES_SVH

`define UDMA_CLK_NS 20
`define UDMA_T_RFS_NS 75
`define UDMA_T_RP_NS 160
// longest time rounds down, least time rounds up
`define UDMA_RFS_CYC (`UDMA_T_RFS_NS / `UDMA_CLK_NS)
`define UDMA_RP_CYC ((`UDMA_T_RP_NS + `UDMA_CLK_NS - 1) / `UDMA_CLK_NS)
`define UDMA_STROBE_GAP 6
`define UDMA_DATA_W 16
`define UDMA_ADDR_W 11
`define UDMA_FIFO_DEPTH 16
`define UDMA_HD_IDLE 16'hFFFF

`endif

// ===== shared/udma_pkg.sv
// state types and pin polarity helper for the burst ends
package udma_pkg;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_REQ = 3'b001,
    D_IN = 3'b010,
    D_OUT = 3'b011,
    D_OUT_TERM = 3'b100,
    D_END = 3'b101
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_IN = 3'b001,
    H_IN_STOP = 3'b010,
    H_IN_END = 3'b011,
    H_OUT = 3'b100,
    H_OUT_END = 3'b101
  } host_state_t;

  // maps an asserted flag to a pin level and back; both directions are the same xnor
  function automatic logic pin_pol(input logic val, input logic active_high);
    pin_pol = ~(val ^ active_high);
  endfunction

endpackage

// ===== shared/udma_if.sv
// pin bundle between the card-side end and the host-side end
`timescale 1ns/1ns
`include "udma_defines.svh"

interface udma_if;
  logic dmarq;
  logic dmack;
  logic iordy;
  logic hioe;
  logic hiow;
  logic [`UDMA_ADDR_W-1:0] ha;
  logic cs0_n;
  logic cs1_n;
  logic [`UDMA_DATA_W-1:0] dev_hd_o;
  logic dev_hd_oe;
  logic [`UDMA_DATA_W-1:0] host_hd_o;
  logic host_hd_oe;
  logic [`UDMA_DATA_W-1:0] hd;

  // resolved data bus; an undriven bus floats high through the pull-ups
  assign hd = dev_hd_oe ? dev_hd_o : (host_hd_oe ? host_hd_o : `UDMA_HD_IDLE);

  modport dev (
    output dmarq, iordy, dev_hd_o, dev_hd_oe,
    input dmack, hioe, hiow, ha, cs0_n, cs1_n, hd
  );
  modport host (
    output dmack, hioe, hiow, ha, cs0_n, cs1_n, host_hd_o, host_hd_oe,
    input dmarq, iordy, hd
  );
endinterface

// ===== core/udma_dev_end.sv
// card-side burst end with its transmit fifo
//
// Contract
// - pins take burst roles only while both asserted
// - data-out burst signals ignored before both asserted
// - burst roles lapse once both negated
// - host stop no sooner than tRP
// - up to three words after pause
// - request/acknowledge polarity follows interface mode
// - address set decoded per interface mode
// - device drives data and strobe in data-in
// - host drives data and strobe in data-out
// - no strobe edge after tRFS; a word launched as the pause arrives still strobes 5 cycles after the pause
// - recipient waits tRP before stopping
`timescale 1ns/1ns
`include "udma_defines.svh"

// ---------------------------------------------
// synchronous fifo
// ---------------------------------------------
module udma_fifo #(
  parameter int WIDTH = `UDMA_DATA_W,
  parameter int DEPTH = `UDMA_FIFO_DEPTH
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // storage has no reset, only pointers do
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end

  // pointer update
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ---------------------------------------------
// card-side end
// ---------------------------------------------
module udma_dev_end #(
  parameter int FIFO_DEPTH = `UDMA_FIFO_DEPTH,
  parameter int STROBE_GAP = `UDMA_STROBE_GAP
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // mode and burst requests
  input wire logic ide_mode,
  input wire logic din_req,
  input wire logic dout_req,
  output logic busy,
  // words to send to the host
  input wire logic [`UDMA_DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // words received from the host
  output logic [`UDMA_DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // register selection
  output logic reg_sel,
  output logic [`UDMA_ADDR_W-1:0] reg_addr,
  // link
  udma_if.dev link
);
  localparam int SW = 3 + `UDMA_ADDR_W + 2 + `UDMA_DATA_W;
  localparam logic [3:0] GAP = 4'(STROBE_GAP);
  localparam logic [3:0] RP = 4'(`UDMA_RP_CYC);
  // filter starts at the pins' idle levels, so no false request or edge follows reset
  localparam logic [SW-1:0] S_IDLE = {1'b0, 1'b1, 1'b1, {`UDMA_ADDR_W{1'b0}}, 1'b1, 1'b1,
    `UDMA_HD_IDLE};

  udma_pkg::dev_state_t state_q;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] f_q;
  logic hioe_prev_q;
  logic dmarq_q;
  logic dir_in_q;
  logic dstrobe_q;
  logic ddmardy_n_q;
  logic pend_q;
  logic [3:0] cnt_q;
  logic [`UDMA_DATA_W-1:0] hd_q;
  logic [`UDMA_DATA_W-1:0] rx_data_q;
  logic rx_valid_q;
  logic f_dmack;
  logic f_hioe;
  logic f_hiow;
  logic [`UDMA_ADDR_W-1:0] f_ha;
  logic f_cs0_n;
  logic f_cs1_n;
  logic [`UDMA_DATA_W-1:0] f_hd;
  logic dmack_a;
  logic burst;
  logic hdmardy_a;
  logic stop_a;
  logic hstrobe_edge;
  logic [`UDMA_DATA_W-1:0] q_data;
  logic q_valid;
  logic launch;

  // ---------------------------------------------
  // input synchroniser with two-of-three agreement
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= S_IDLE;
      s2_q <= S_IDLE;
      s3_q <= S_IDLE;
      f_q <= S_IDLE;
      hioe_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      // acknowledge enters as its asserted sense: active low in true ide mode
      s1_q <= {udma_pkg::pin_pol(link.dmack, ~ide_mode), link.hioe, link.hiow, link.ha,
        link.cs0_n, link.cs1_n, link.hd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
      hioe_prev_q <= f_hioe;
    end
  end

  assign {f_dmack, f_hioe, f_hiow, f_ha, f_cs0_n, f_cs1_n, f_hd} = f_q;

  // acknowledge was decoded to its asserted sense ahead of the filter
  assign dmack_a = f_dmack;
  assign burst = dmarq_q && dmack_a;
  // read and write strobes only mean something inside a burst
  assign hdmardy_a = burst && !f_hioe;
  assign stop_a = burst && f_hiow;
  assign hstrobe_edge = burst && !dir_in_q && (f_hioe != hioe_prev_q);

  // register selection from whichever address set the mode uses
  assign reg_addr = ide_mode ? {8'h00, f_ha[2:0]} : f_ha;
  assign reg_sel = !f_cs0_n || !f_cs1_n;

  // ---------------------------------------------
  // transmit fifo between user and link
  // ---------------------------------------------
  udma_fifo #(
    .WIDTH(`UDMA_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) tx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(launch)
  );

  // a word launches only while the host is ready; a host pause therefore
  // backs the fifo up to the user; sync delay lets up to three words slip
  assign launch = ce && state_q == udma_pkg::D_IN && !pend_q && cnt_q == 4'h0
    && hdmardy_a && !stop_a && q_valid;

  // ---------------------------------------------
  // burst sequencer
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= udma_pkg::D_IDLE;
      dmarq_q <= 1'b0;
      dir_in_q <= 1'b0;
      dstrobe_q <= 1'b1;
      ddmardy_n_q <= 1'b1;
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      hd_q <= '0;
    end
    else if (ce)
    begin
      if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      unique case (state_q)
        udma_pkg::D_IDLE:
        begin
          dstrobe_q <= 1'b1;
          ddmardy_n_q <= 1'b1;
          if (din_req || dout_req)
          begin
            dmarq_q <= 1'b1;
            dir_in_q <= din_req;
            state_q <= udma_pkg::D_REQ;
          end
        end
        udma_pkg::D_REQ:
        begin
          if (dmack_a)
            state_q <= dir_in_q ? udma_pkg::D_IN : udma_pkg::D_OUT;
        end
        udma_pkg::D_IN:
        begin
          // data goes out one cycle ahead of its strobe edge
          if (launch)
          begin
            hd_q <= q_data;
            pend_q <= 1'b1;
            cnt_q <= GAP;
          end
          else if (pend_q)
          begin
            dstrobe_q <= !dstrobe_q;
            pend_q <= 1'b0;
          end
          if (!pend_q && (stop_a || (!din_req && !q_valid)))
          begin
            dmarq_q <= 1'b0;
            state_q <= udma_pkg::D_END;
          end
        end
        udma_pkg::D_OUT:
        begin
          ddmardy_n_q <= !rx_ready;
          if (stop_a)
          begin
            dmarq_q <= 1'b0;
            state_q <= udma_pkg::D_END;
          end
          else if (!dout_req)
          begin
            ddmardy_n_q <= 1'b1;
            cnt_q <= RP;
            state_q <= udma_pkg::D_OUT_TERM;
          end
        end
        udma_pkg::D_OUT_TERM:
        begin
          // ready is already negated; hold off the stop for tRP
          if (cnt_q == 4'h0 || stop_a)
          begin
            dmarq_q <= 1'b0;
            state_q <= udma_pkg::D_END;
          end
        end
        udma_pkg::D_END:
        begin
          if (!dmack_a)
          begin
            dstrobe_q <= 1'b1;
            ddmardy_n_q <= 1'b1;
            state_q <= udma_pkg::D_IDLE;
          end
        end
        default:
          state_q <= udma_pkg::D_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // receive capture on host strobe edges
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      // data comes through the same filter as the strobe, so both align
      rx_valid_q <= hstrobe_edge;
      if (hstrobe_edge)
        rx_data_q <= f_hd;
    end
  end

  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign busy = state_q != udma_pkg::D_IDLE;

  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  assign link.dmarq = udma_pkg::pin_pol(dmarq_q, ide_mode);
  // outside a burst iordy just reports ready
  assign link.iordy = !(dmarq_q && dmack_a) ? 1'b1
    : (dir_in_q ? dstrobe_q : ddmardy_n_q);
  assign link.dev_hd_o = hd_q;
  assign link.dev_hd_oe = state_q == udma_pkg::D_IN && burst;
endmodule

// ===== core/udma_host_end.sv
// host-side burst end
`timescale 1ns/1ns
`include "udma_defines.svh"

module udma_host_end #(
  parameter int STROBE_GAP = `UDMA_STROBE_GAP
) (
  // clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // mode and burst control
  input wire logic ide_mode,
  input wire logic dir_in,
  input wire logic stop_req,
  output logic busy,
  // register selection
  input wire logic [`UDMA_ADDR_W-1:0] addr,
  input wire logic [1:0] cs,
  // words to send to the device
  input wire logic [`UDMA_DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // words received from the device
  output logic [`UDMA_DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // link
  udma_if.host link
);
  localparam int SW = 2 + `UDMA_DATA_W;
  localparam logic [3:0] GAP = 4'(STROBE_GAP);
  localparam logic [3:0] RP = 4'(`UDMA_RP_CYC);
  // filter starts negated and idle, so reset never looks like a burst request
  localparam logic [SW-1:0] S_IDLE = {1'b0, 1'b1, `UDMA_HD_IDLE};

  udma_pkg::host_state_t state_q;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  logic [SW-1:0] f_q;
  logic iordy_prev_q;
  logic dmack_q;
  logic hioe_q;
  logic hiow_q;
  logic pend_q;
  logic [3:0] cnt_q;
  logic [`UDMA_DATA_W-1:0] hd_q;
  logic hd_oe_q;
  logic [`UDMA_DATA_W-1:0] rx_data_q;
  logic rx_valid_q;
  logic [`UDMA_ADDR_W-1:0] ha_q;
  logic [1:0] cs_n_q;
  logic f_dmarq;
  logic f_iordy;
  logic [`UDMA_DATA_W-1:0] f_hd;
  logic dmarq_a;
  logic burst;
  logic dstrobe_edge;
  logic rx_phase;

  // ---------------------------------------------
  // input synchroniser with two-of-three agreement
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= S_IDLE;
      s2_q <= S_IDLE;
      s3_q <= S_IDLE;
      f_q <= S_IDLE;
      iordy_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      s1_q <= {udma_pkg::pin_pol(link.dmarq, ide_mode), link.iordy, link.hd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
      iordy_prev_q <= f_iordy;
    end
  end

  assign {f_dmarq, f_iordy, f_hd} = f_q;
  assign dmarq_a = f_dmarq;
  assign burst = dmarq_a && dmack_q;
  assign rx_phase = state_q == udma_pkg::H_IN || state_q == udma_pkg::H_IN_STOP;
  assign dstrobe_edge = burst && rx_phase && (f_iordy != iordy_prev_q);

  // a word goes out only while the device shows ready
  assign tx_ready = ce && state_q == udma_pkg::H_OUT && burst && !pend_q
    && cnt_q == 4'h0 && !f_iordy && !stop_req;

  // ---------------------------------------------
  // burst sequencer
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= udma_pkg::H_IDLE;
      dmack_q <= 1'b0;
      hioe_q <= 1'b1;
      hiow_q <= 1'b1;
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      hd_q <= '0;
      hd_oe_q <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      unique case (state_q)
        udma_pkg::H_IDLE:
        begin
          if (dmarq_a)
          begin
            dmack_q <= 1'b1;
            hiow_q <= 1'b0;
            hioe_q <= dir_in ? !rx_ready : 1'b1;
            state_q <= dir_in ? udma_pkg::H_IN : udma_pkg::H_OUT;
          end
        end
        udma_pkg::H_IN:
        begin
          hioe_q <= !rx_ready;
          if (!dmarq_a)
            state_q <= udma_pkg::H_IN_END;
          else if (stop_req)
          begin
            // pause first, stop only after tRP
            hioe_q <= 1'b1;
            cnt_q <= RP;
            state_q <= udma_pkg::H_IN_STOP;
          end
        end
        udma_pkg::H_IN_STOP:
        begin
          if (!dmarq_a)
            state_q <= udma_pkg::H_IN_END;
          else if (cnt_q == 4'h0)
          begin
            hiow_q <= 1'b1;
            state_q <= udma_pkg::H_IN_END;
          end
        end
        udma_pkg::H_IN_END:
        begin
          if (!dmarq_a)
          begin
            dmack_q <= 1'b0;
            hioe_q <= 1'b1;
            hiow_q <= 1'b1;
            state_q <= udma_pkg::H_IDLE;
          end
        end
        udma_pkg::H_OUT:
        begin
          if (tx_ready && tx_valid)
          begin
            hd_q <= tx_data;
            hd_oe_q <= 1'b1;
            pend_q <= 1'b1;
            cnt_q <= GAP;
          end
          else if (pend_q)
          begin
            hioe_q <= !hioe_q;
            pend_q <= 1'b0;
          end
          if (!pend_q && !dmarq_a)
            state_q <= udma_pkg::H_OUT_END;
          else if (!pend_q && stop_req && dmack_q)
          begin
            hiow_q <= 1'b1;
            state_q <= udma_pkg::H_OUT_END;
          end
        end
        udma_pkg::H_OUT_END:
        begin
          if (!dmarq_a)
          begin
            dmack_q <= 1'b0;
            hioe_q <= 1'b1;
            hiow_q <= 1'b1;
            hd_oe_q <= 1'b0;
            state_q <= udma_pkg::H_IDLE;
          end
        end
        default:
          state_q <= udma_pkg::H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // receive capture and address outputs
  // ---------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      ha_q <= '0;
      cs_n_q <= 2'h3;
    end
    else if (ce)
    begin
      // no back-pressure here: after a pause the device may still send words
      rx_valid_q <= dstrobe_edge;
      if (dstrobe_edge)
        rx_data_q <= f_hd;
      ha_q <= ide_mode ? {8'h00, addr[2:0]} : addr;
      cs_n_q <= ~cs;
    end
  end

  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign busy = state_q != udma_pkg::H_IDLE;

  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  assign link.dmack = udma_pkg::pin_pol(dmack_q, ~ide_mode);
  assign link.hioe = hioe_q;
  assign link.hiow = hiow_q;
  assign link.ha = ha_q;
  assign link.cs0_n = cs_n_q[0];
  assign link.cs1_n = cs_n_q[1];
  assign link.host_hd_o = hd_q;
  assign link.host_hd_oe = hd_oe_q && dmack_q;
endmodule

// ===== verification/udma_burst_assertions.sv
// concurrent checks on the pin bundle between the two burst ends
`timescale 1ns/1ns

module udma_burst_assertions (
  // clocking and mode
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ide_mode,
  // handshake pins
  input wire logic dmarq,
  input wire logic dmack,
  input wire logic iordy,
  input wire logic hioe,
  input wire logic hiow,
  // data bus enables
  input wire logic dev_hd_oe,
  input wire logic host_hd_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic rq;
  logic ak;
  logic iordy_q;
  logic [2:0] extra_q;
  logic [3:0] hold_q;

  // asserted request and acknowledge, whatever the mode's polarity
  assign rq = (dmarq == ide_mode);
  assign ak = (dmack != ide_mode);

  // previous strobe level, to see its edges
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      iordy_q <= 1'b1;
    else
      iordy_q <= iordy;
  end

  // strobe edges after the host paused; saturates so it cannot wrap back to legal
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      extra_q <= 3'h0;
    else if (!hioe || !dev_hd_oe)
      extra_q <= 3'h0;
    else if (iordy != iordy_q && extra_q != 3'h7)
      extra_q <= extra_q + 3'h1;
  end

  // cycles the host ready has stayed negated
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      hold_q <= 4'h0;
    else if (!hioe)
      hold_q <= 4'h0;
    else if (hold_q != 4'hF)
      hold_q <= hold_q + 4'h1;
  end

  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  sequence s_quiet;
    (!rq && !ak)[*8];
  endsequence
  sequence s_din_edge;
    $changed(iordy) && dev_hd_oe && ak;
  endsequence

  property p_no_contention;
    !(dev_hd_oe && host_hd_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data bus");
  property p_din_drive;
    $rose(dev_hd_oe) |-> rq && ak;
  endproperty
  a_din_drive: assert property (p_din_drive)
    else $error("device drove data outside a burst");
  property p_dout_drive;
    $rose(host_hd_oe) |-> rq && ak;
  endproperty
  a_dout_drive: assert property (p_dout_drive)
    else $error("host drove data outside a burst");
  property p_ack_follows;
    $rose(ak) |-> $past(rq, 3);
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("acknowledge without a seen request");
  property p_idle_roles;
    s_quiet |-> iordy && hioe && hiow;
  endproperty
  a_idle_roles: assert property (p_idle_roles)
    else $error("pins not back at idle levels");
  property p_ack_release;
    $fell(rq) && ak |-> ##[1:16] !ak;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge held after request negated");
  property p_din_gap;
    s_din_edge |=> (!ak || $stable(iordy))[*6];
  endproperty
  a_din_gap: assert property (p_din_gap)
    else $error("device strobe edges too close");
  property p_dout_gap;
    $changed(hioe) && host_hd_oe && rq |=> (!rq || $stable(hioe))[*6];
  endproperty
  a_dout_gap: assert property (p_dout_gap)
    else $error("host strobe edges too close");
  property p_pause_words;
    extra_q < 3'h4;
  endproperty
  a_pause_words: assert property (p_pause_words)
    else $error("more than three words after pause");
  property p_stop_wait;
    $rose(hiow) && rq && ak && dev_hd_oe |-> hold_q >= 4'h8;
  endproperty
  a_stop_wait: assert property (p_stop_wait)
    else $error("stop raised before ready-to-pause time");
endmodule

// ===== verification/ultra_dma_burst_port_tb.sv
// testbench joining both burst ends across the pin bundle
`timescale 1ns/1ns
`include "udma_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module ultra_dma_burst_port_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ide_mode = 1'b1, ce = 1'b1;
  logic [2:0] frz;
  logic din_req = 1'b0, dout_req = 1'b0, dir_in = 1'b1, stop_req = 1'b0;
  logic [15:0] d_tx_data = 16'h0000, h_tx_data = 16'h0000;
  logic d_tx_valid = 1'b0, h_tx_valid = 1'b0, d_rx_ready = 1'b1, h_rx_ready = 1'b1;
  logic [10:0] addr = 11'h000;
  logic [1:0] cs = 2'h0;
  logic [5:0] tick = 6'h00;
  logic d_busy, h_busy, d_tx_ready, h_tx_ready, d_rx_valid, h_rx_valid, reg_sel;
  logic [15:0] d_rx_data, h_rx_data;
  logic [10:0] reg_addr;
  logic [15:0] hq[$], dq[$];
  int n_mismatch = 0, checked = 0;

  udma_if lnk();
  udma_dev_end i_udma_dev_end (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .ide_mode(ide_mode), .din_req(din_req),
    .dout_req(dout_req), .busy(d_busy), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
    .tx_ready(d_tx_ready), .rx_data(d_rx_data), .rx_valid(d_rx_valid),
    .rx_ready(d_rx_ready), .reg_sel(reg_sel), .reg_addr(reg_addr), .link(lnk));
  udma_host_end i_udma_host_end (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .ide_mode(ide_mode), .dir_in(dir_in),
    .stop_req(stop_req), .busy(h_busy), .addr(addr), .cs(cs), .tx_data(h_tx_data),
    .tx_valid(h_tx_valid), .tx_ready(h_tx_ready), .rx_data(h_rx_data),
    .rx_valid(h_rx_valid), .rx_ready(h_rx_ready), .link(lnk));
  udma_burst_assertions i_udma_burst_assertions (
    .sys_clk(sys_clk), .rst(rst), .ide_mode(ide_mode), .dmarq(lnk.dmarq),
    .dmack(lnk.dmack), .iordy(lnk.iordy), .hioe(lnk.hioe), .hiow(lnk.hiow),
    .dev_hd_oe(lnk.dev_hd_oe), .host_hd_oe(lnk.host_hd_oe));

  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;

  // receivers pause a quarter of the time so both ends see stalls
  always @(posedge sys_clk)
  begin
    tick <= tick + 6'h01;
    h_rx_ready <= |tick[5:4];
    d_rx_ready <= |tick[5:4];
  end

  // words collected as each end hands them up; a frozen pulse counts once
  always @(posedge sys_clk)
  begin
    if (ce && h_rx_valid === 1'b1) hq.push_back(h_rx_data);
    if (ce && d_rx_valid === 1'b1) dq.push_back(d_rx_data);
  end

  // ---------------------------------------------
  // access tasks
  // ---------------------------------------------
  function automatic logic [15:0] wd(input int i);
    wd = 16'hC3A0 + 16'(i) * 16'h0107;
  endfunction

  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // the synchronisers fill for a few edges after release, so requests wait
  task automatic do_reset(input logic m);
    rst <= 1'b1;
    ide_mode <= m;
    cyc(8);
    rst <= 1'b0;
    cyc(6);
  endtask

  // offer one word; valid stays up so back-to-back words need no gap
  task automatic push(input bit hs, input logic [15:0] w);
    logic rd;
    int i;
    if (hs)
    begin
      h_tx_data <= w;
      h_tx_valid <= 1'b1;
    end
    else
    begin
      d_tx_data <= w;
      d_tx_valid <= 1'b1;
    end
    for (i = 0; i < 400; i++)
    begin
      @(negedge sys_clk);
      rd = hs ? h_tx_ready : d_tx_ready;
      @(posedge sys_clk);
      if (rd === 1'b1) break;
    end
    if (i == 400) begin n_mismatch++; end_sim(); end
  endtask

  task automatic wait_words(input int n, input bit hs);
    int i;
    for (i = 0; i < 4000 && (hs ? hq.size() : dq.size()) < n; i++) cyc(1);
    if (i == 4000) begin n_mismatch++; end_sim(); end
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && (d_busy !== 1'b0 || h_busy !== 1'b0); i++) cyc(1);
    if (i == 3000) begin n_mismatch++; end_sim(); end
    cyc(12);
  endtask

  // pin levels looked at mid-cycle, away from the edge
  task automatic pins(input logic m, input logic bst, input logic din);
    @(negedge sys_clk);
    `CHK(lnk.dmarq, bst ? m : ~m)
    `CHK(lnk.dmack, bst ? ~m : m)
    if (bst)
    begin
      `CHK(lnk.dev_hd_oe, din)
      `CHK(lnk.host_hd_oe, ~din)
    end
    else
    begin
      `CHK({lnk.iordy, lnk.hioe, lnk.hiow}, 3'h7)
      `CHK(lnk.hd, 16'hFFFF)
    end
    @(posedge sys_clk);
  endtask

  // ---------------------------------------------
  // scenarios, once per interface mode
  // ---------------------------------------------
  initial
  begin
    for (int m = 1; m >= 0; m--)
    begin
      do_reset(m[0]);
      addr <= 11'h5A5;
      cs <= 2'b01;
      cyc(8);
      `CHK(reg_sel, 1'b1)
      `CHK(reg_addr, m ? 11'h005 : 11'h5A5)
      cs <= 2'b10;
      cyc(8);
      `CHK(reg_sel, 1'b1)
      cs <= 2'b00;
      cyc(8);
      `CHK(reg_sel, 1'b0)
      pins(m[0], 1'b0, 1'b0);
      for (int i = 0; i < 16; i++) push(1'b0, wd(i));
      d_tx_valid <= 1'b0;
      @(negedge sys_clk);
      `CHK(d_tx_ready, 1'b0)
      @(posedge sys_clk);
      hq.delete();
      din_req <= 1'b1;
      wait_words(4, 1'b1);
      pins(m[0], 1'b1, 1'b1);
      `CHK(lnk.hiow, 1'b0)
      // clock enable low: iordy, hioe and dmarq may not move
      ce <= 1'b0;
      cyc(1);
      frz = {lnk.iordy, lnk.hioe, lnk.dmarq};
      cyc(20);
      `CHK({lnk.iordy, lnk.hioe, lnk.dmarq}, frz)
      ce <= 1'b1;
      wait_words(16, 1'b1);
      din_req <= 1'b0;
      wait_idle();
      pins(m[0], 1'b0, 1'b0);
      `CHK(hq.size(), 16)
      foreach (hq[i]) `CHK(hq[i], wd(i))
      dq.delete();
      dir_in <= 1'b0;
      cyc(1);
      dout_req <= 1'b1;
      for (int i = 0; i < 6; i++) push(1'b1, ~wd(i));
      h_tx_valid <= 1'b0;
      pins(m[0], 1'b1, 1'b0);
      wait_words(6, 1'b0);
      // pc card run ends the data-out burst from the host side instead
      if (m == 0)
      begin
        stop_req <= 1'b1;
        cyc(8);
      end
      dout_req <= 1'b0;
      wait_idle();
      stop_req <= 1'b0;
      pins(m[0], 1'b0, 1'b0);
      `CHK(dq.size(), 6)
      foreach (dq[i]) `CHK(dq[i], ~wd(i))
      for (int i = 0; i < 8; i++) push(1'b0, wd(i));
      d_tx_valid <= 1'b0;
      hq.delete();
      dir_in <= 1'b1;
      cyc(1);
      din_req <= 1'b1;
      wait_words(2, 1'b1);
      stop_req <= 1'b1;
      din_req <= 1'b0;
      cyc(2);
      wait_idle();
      stop_req <= 1'b0;
      pins(m[0], 1'b0, 1'b0);
      `CHK(hq.size() < 8, 1'b1)
      foreach (hq[i]) `CHK(hq[i], wd(i))
    end
    end_sim();
  end
endmodule
